// ==== rtl/gfm_defs.svh ====
/*
 * Register indices, reset values and timing counts of the
 * leakage/thermistor option block. Assumes inclusion by bare name.
 */
`ifndef GFM_DEFS_SVH
`define GFM_DEFS_SVH

// Register indices, byte address is four times the index
`define GFM_IDX_STATUS    6'h01
`define GFM_IDX_FAULT_EN  6'h02
`define GFM_IDX_ALARM_EN  6'h03
`define GFM_IDX_RESTART   6'h04
`define GFM_IDX_TURNS     6'h05
`define GFM_IDX_TRIP_LVL  6'h06
`define GFM_IDX_TRIP_DLY  6'h07
`define GFM_IDX_ALM_LVL   6'h08
`define GFM_IDX_ALM_DLY   6'h09
`define GFM_IDX_INHIBIT   6'h0a
`define GFM_IDX_READING   6'h0b
`define GFM_IDX_SENS_EN   6'h0c
`define GFM_IDX_GAIN_A    6'h0d
`define GFM_IDX_GAIN_C    6'h0f
`define GFM_IDX_ANGLE_A   6'h10
`define GFM_IDX_ANGLE_C   6'h12
`define GFM_IDX_DEFAULTS  6'h13
`define GFM_IDX_IRQ_STAT  6'h14
`define GFM_IDX_IRQ_MASK  6'h15
`define GFM_IDX_TUNE      6'h16

// Status and mask bit positions
`define GFM_ST_READY      0
`define GFM_ST_THERM      1
`define GFM_ST_LOSS       2
`define GFM_EN_THERM      0
`define GFM_EN_LEAK       1

// Interrupt bits
`define GFM_IRQ_TRIP      0
`define GFM_IRQ_ALARM     1
`define GFM_IRQ_CAL       2
`define GFM_IRQ_THERM     3
`define GFM_IRQ_LOSS      4
`define GFM_IRQ_W         5

// Reset values; levels in 0.01 A, times in 0.1 s
`define GFM_RST_TURNS     16'h03e8
`define GFM_RST_LEVEL     16'h00fa
`define GFM_RST_DELAY     16'h0005
`define GFM_RST_INHIBIT   16'h0064
`define GFM_RST_GAIN      16'h0064
`define GFM_MAX_AMPS      16'h01f4

// Timing: time unit of delay registers and test button hold
`define GFM_TICK_MS       100
`define GFM_CLK_KHZ       50000
`define GFM_BTN_TICKS     8'h64

`endif

// ==== rtl/gfm_pkg.sv ====
/*
 * Types of the leakage/thermistor option block.
 * Assumes gfm_defs.svh is on the include path.
 */
package gfm_pkg;

    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_RUN
    } gfm_cal_state_t;

    // Calibration results delivered by the measuring engine
    typedef struct packed {
        logic [15:0] gain_a;
        logic [15:0] gain_b;
        logic [15:0] gain_c;
        logic [15:0] angle_a;
        logic [15:0] angle_b;
        logic [15:0] angle_c;
    } gfm_cal_result_t;

    // Motor controller context
    typedef struct packed {
        logic start_cmd;
        logic starting;
        logic stopped;
        logic test_pushbutton;
    } gfm_motor_t;

    // Protection outputs
    typedef struct packed {
        logic therm_fault;
        logic therm_alarm;
        logic leak_fault;
        logic leak_alarm;
    } gfm_prot_t;

    typedef struct packed {
        logic [7:0]      fault_en;
        logic [7:0]      alarm_en;
        logic [7:0]      restart_en;
        logic [15:0]     turns;
        logic [15:0]     trip_lvl;
        logic [15:0]     trip_dly;
        logic [15:0]     alm_lvl;
        logic [15:0]     alm_dly;
        logic [15:0]     inhibit;
        logic [15:0]     reading;
        logic            sens_en;
        gfm_cal_result_t cal;
        logic            cal_valid;
        gfm_cal_state_t  cal_st;
        logic [4:0]      irq_st;
        logic [4:0]      irq_mask;
        logic [22:0]     tick_cnt;
        logic [15:0]     trip_cnt;
        logic [15:0]     alm_cnt;
        logic [15:0]     inh_cnt;
        logic [7:0]      btn_cnt;
        logic            leak_trip;
        logic            leak_alarm;
        logic            therm_q;
        logic            loss_q;
        logic [31:0]     prdata;
    } gfm_state_t;

endpackage

// ==== rtl/gfm_core.sv ====
/*
 * Leakage current, thermistor and phase sensor option block with an
 * APB register bank, protection timers and calibration sequencing.
 * Assumes all inputs are synchronous to ref_clk_i and that the
 * calibration engine answers cal_req_o with a cal_done_i pulse.
 */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "gfm_defs.svh"

////////////////////////////////////////////////////////////////////////
// Functional notes
// - With the external sensor enabled, each phase channel is calibrated for gain and angle.
// - Calibration runs before the first start after installation when the sensor enable is set.
// - Calibration also runs after a restore of default parameters.
// - With the sensor enable set, calibration runs on a tuning request or a test button hold over 10 s while stopped.
// - The status word shows ready in bit 0, thermistor in bit 1 and sensor loss in bit 2, 1 active.
// - Fault, alarm and restart masks use bit 0 for thermistor and bit 1 for leakage, 1 enables; the restart mask is only stored and read back.
// - Leakage reading, trip level and alarm level are limited to 5.00 A.
// - Leakage protection is held off during starting for the inhibit time, default 10.0 s.
module gfm_core
    import gfm_pkg::*;
#(
    parameter int TICK_CYCLES = `GFM_TICK_MS * `GFM_CLK_KHZ
) (
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            rst_n_i,
    // APB slave
    input  wire logic            psel_i,
    input  wire logic            penable_i,
    input  wire logic            pwrite_i,
    input  wire logic [7:0]      paddr_i,
    input  wire logic [31:0]     pwdata_i,
    output logic                 pready_o,
    output logic                 pslverr_o,
    output logic [31:0]          prdata_o,
    // Sensors
    input  wire logic            thermistor_input_i,
    input  wire logic            sensor_loss_i,
    input  wire logic [15:0]     leak_current_i,
    // Motor controller
    input  wire gfm_motor_t      motor_i,
    output logic                 start_permit_o,
    // Calibration engine
    output logic                 cal_req_o,
    input  wire logic            cal_done_i,
    input  wire gfm_cal_result_t cal_result_i,
    // Protection and interrupt
    output gfm_prot_t            prot_o,
    output logic                 irq_o
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] clamp_amps(input logic [15:0] v);
        clamp_amps = (v > `GFM_MAX_AMPS) ? `GFM_MAX_AMPS : v;
    endfunction

    // Delay counter: advances on tick while over level, else clears
    function automatic logic [15:0] dwell(input logic [15:0] cnt,
                                         input logic over,
                                         input logic tick);
        if (!over) begin
            dwell = 16'h0000;
        end else if (tick && cnt != 16'hffff) begin
            dwell = cnt + 16'h0001;
        end else begin
            dwell = cnt;
        end
    endfunction

    function automatic logic [31:0] pad16(input logic [15:0] v);
        pad16 = {16'h0000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    gfm_state_t s_reg;
    gfm_state_t s_next;

    logic [5:0] idx;
    logic       setup;
    logic       wr;
    logic       mapped;
    logic       tick;
    logic       hold_off;
    logic       leak_over;
    logic       alm_over;
    logic       cal_kick;
    logic       restore;
    logic [4:0] ev;
    logic [31:0] rd;

    localparam logic [22:0] TICK_LAST = 23'(TICK_CYCLES - 1);

    assign idx   = paddr_i[7:2];
    assign setup = psel_i && !penable_i;
    assign wr    = psel_i && penable_i && pwrite_i && mapped;

    always_comb begin
        mapped = (idx >= `GFM_IDX_STATUS) && (idx <= `GFM_IDX_TUNE);
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        rd = 32'h0000_0000;
        if (idx == `GFM_IDX_STATUS) begin
            rd[`GFM_ST_READY] = s_reg.cal_st == CAL_IDLE;
            rd[`GFM_ST_THERM] = s_reg.therm_q;
            rd[`GFM_ST_LOSS]  = s_reg.loss_q;
        end else if (idx == `GFM_IDX_FAULT_EN) begin
            rd = {24'h000000, s_reg.fault_en};
        end else if (idx == `GFM_IDX_ALARM_EN) begin
            rd = {24'h000000, s_reg.alarm_en};
        end else if (idx == `GFM_IDX_RESTART) begin
            rd = {24'h000000, s_reg.restart_en};
        end else if (idx == `GFM_IDX_TURNS) begin
            rd = pad16(s_reg.turns);
        end else if (idx == `GFM_IDX_TRIP_LVL) begin
            rd = pad16(s_reg.trip_lvl);
        end else if (idx == `GFM_IDX_TRIP_DLY) begin
            rd = pad16(s_reg.trip_dly);
        end else if (idx == `GFM_IDX_ALM_LVL) begin
            rd = pad16(s_reg.alm_lvl);
        end else if (idx == `GFM_IDX_ALM_DLY) begin
            rd = pad16(s_reg.alm_dly);
        end else if (idx == `GFM_IDX_INHIBIT) begin
            rd = pad16(s_reg.inhibit);
        end else if (idx == `GFM_IDX_READING) begin
            rd = pad16(s_reg.reading);
        end else if (idx == `GFM_IDX_SENS_EN) begin
            rd = {31'h0000_0000, s_reg.sens_en};
        end else if (idx == `GFM_IDX_GAIN_A) begin
            rd = pad16(s_reg.cal.gain_a);
        end else if (idx == 6'(`GFM_IDX_GAIN_A + 6'h01)) begin
            rd = pad16(s_reg.cal.gain_b);
        end else if (idx == `GFM_IDX_GAIN_C) begin
            rd = pad16(s_reg.cal.gain_c);
        end else if (idx == `GFM_IDX_ANGLE_A) begin
            rd = pad16(s_reg.cal.angle_a);
        end else if (idx == 6'(`GFM_IDX_ANGLE_A + 6'h01)) begin
            rd = pad16(s_reg.cal.angle_b);
        end else if (idx == `GFM_IDX_ANGLE_C) begin
            rd = pad16(s_reg.cal.angle_c);
        end else if (idx == `GFM_IDX_IRQ_STAT) begin
            rd = {27'h000_0000, s_reg.irq_st};
        end else if (idx == `GFM_IDX_IRQ_MASK) begin
            rd = {27'h000_0000, s_reg.irq_mask};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_next = s_reg;
        tick   = s_reg.tick_cnt == TICK_LAST;
        restore = wr && idx == `GFM_IDX_DEFAULTS && pwdata_i[0];

        // Prepare read data a cycle early so prdata comes from a flop
        if (setup) begin
            s_next.prdata = rd;
        end

        // Tenth-second time base
        s_next.tick_cnt = tick ? 23'h000000 : s_reg.tick_cnt + 23'h000001;

        // Sensor sampling
        s_next.therm_q = thermistor_input_i;
        s_next.loss_q  = sensor_loss_i;
        s_next.reading = clamp_amps(leak_current_i);

        // Register writes
        if (wr) begin
            if (idx == `GFM_IDX_FAULT_EN) begin
                s_next.fault_en = pwdata_i[7:0];
            end else if (idx == `GFM_IDX_ALARM_EN) begin
                s_next.alarm_en = pwdata_i[7:0];
            end else if (idx == `GFM_IDX_RESTART) begin
                s_next.restart_en = pwdata_i[7:0];
            end else if (idx == `GFM_IDX_TURNS) begin
                s_next.turns = pwdata_i[15:0];
            end else if (idx == `GFM_IDX_TRIP_LVL) begin
                s_next.trip_lvl = clamp_amps(pwdata_i[15:0]);
            end else if (idx == `GFM_IDX_TRIP_DLY) begin
                s_next.trip_dly = pwdata_i[15:0];
            end else if (idx == `GFM_IDX_ALM_LVL) begin
                s_next.alm_lvl = clamp_amps(pwdata_i[15:0]);
            end else if (idx == `GFM_IDX_ALM_DLY) begin
                s_next.alm_dly = pwdata_i[15:0];
            end else if (idx == `GFM_IDX_INHIBIT) begin
                s_next.inhibit = pwdata_i[15:0];
            end else if (idx == `GFM_IDX_SENS_EN) begin
                s_next.sens_en = pwdata_i[0];
            end else if (idx == `GFM_IDX_IRQ_MASK) begin
                s_next.irq_mask = pwdata_i[4:0];
            end
        end

        // Restore defaults; forces a fresh calibration
        if (restore) begin
            s_next.fault_en   = 8'h00;
            s_next.alarm_en   = 8'h00;
            s_next.restart_en = 8'h00;
            s_next.turns      = `GFM_RST_TURNS;
            s_next.trip_lvl   = `GFM_RST_LEVEL;
            s_next.trip_dly   = `GFM_RST_DELAY;
            s_next.alm_lvl    = `GFM_RST_LEVEL;
            s_next.alm_dly    = `GFM_RST_DELAY;
            s_next.inhibit    = `GFM_RST_INHIBIT;
            s_next.sens_en    = 1'b0;
            s_next.cal_valid  = 1'b0;
        end

        // Test button hold while stopped
        if (motor_i.test_pushbutton && motor_i.stopped) begin
            if (tick && s_reg.btn_cnt != 8'hff) begin
                s_next.btn_cnt = s_reg.btn_cnt + 8'h01;
            end
        end else begin
            s_next.btn_cnt = 8'h00;
        end

        // Calibration triggers
        cal_kick = 1'b0;
        if (wr && idx == `GFM_IDX_TUNE && pwdata_i[0]) begin
            cal_kick = 1'b1;
        end
        if (tick && s_reg.btn_cnt == `GFM_BTN_TICKS) begin
            cal_kick = 1'b1;
        end
        if (restore) begin
            cal_kick = 1'b1;
        end
        if (motor_i.start_cmd && s_reg.sens_en && !s_reg.cal_valid) begin
            cal_kick = 1'b1;
        end

        case (s_reg.cal_st)
            CAL_IDLE: begin
                if (cal_kick && (s_reg.sens_en || restore)) begin
                    s_next.cal_st = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (cal_done_i) begin
                    s_next.cal       = cal_result_i;
                    s_next.cal_valid = 1'b1;
                    s_next.cal_st    = CAL_IDLE;
                end
            end
            default: begin
                s_next.cal_st = CAL_IDLE;
            end
        endcase

        // Start inhibit window
        if (motor_i.start_cmd && start_permit_o) begin
            s_next.inh_cnt = s_reg.inhibit;
        end else if (!motor_i.starting) begin
            s_next.inh_cnt = 16'h0000;
        end else if (tick && s_reg.inh_cnt != 16'h0000) begin
            s_next.inh_cnt = s_reg.inh_cnt - 16'h0001;
        end
        hold_off = motor_i.starting && s_reg.inh_cnt != 16'h0000;

        // Leakage dwell timers
        leak_over = !hold_off && s_reg.reading > s_reg.trip_lvl;
        alm_over  = !hold_off && s_reg.reading > s_reg.alm_lvl;
        s_next.trip_cnt   = dwell(s_reg.trip_cnt, leak_over, tick);
        s_next.alm_cnt    = dwell(s_reg.alm_cnt, alm_over, tick);
        s_next.leak_trip  = leak_over && s_reg.trip_cnt >= s_reg.trip_dly;
        s_next.leak_alarm = alm_over && s_reg.alm_cnt >= s_reg.alm_dly;

        // Sticky events; a new event beats a same-cycle clear
        ev = 5'h00;
        ev[`GFM_IRQ_TRIP]  = s_next.leak_trip && !s_reg.leak_trip;
        ev[`GFM_IRQ_ALARM] = s_next.leak_alarm && !s_reg.leak_alarm;
        ev[`GFM_IRQ_CAL]   = s_reg.cal_st == CAL_RUN && cal_done_i;
        ev[`GFM_IRQ_THERM] = thermistor_input_i && !s_reg.therm_q;
        ev[`GFM_IRQ_LOSS]  = sensor_loss_i && !s_reg.loss_q;
        if (wr && idx == `GFM_IDX_IRQ_STAT) begin
            s_next.irq_st = s_reg.irq_st & ~pwdata_i[4:0];
        end
        s_next.irq_st = s_next.irq_st | ev;
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_reg            <= '0;
            s_reg.turns      <= `GFM_RST_TURNS;
            s_reg.trip_lvl   <= `GFM_RST_LEVEL;
            s_reg.trip_dly   <= `GFM_RST_DELAY;
            s_reg.alm_lvl    <= `GFM_RST_LEVEL;
            s_reg.alm_dly    <= `GFM_RST_DELAY;
            s_reg.inhibit    <= `GFM_RST_INHIBIT;
            s_reg.cal.gain_a <= `GFM_RST_GAIN;
            s_reg.cal.gain_b <= `GFM_RST_GAIN;
            s_reg.cal.gain_c <= `GFM_RST_GAIN;
            s_reg.cal_st     <= CAL_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Start held back until a pending first calibration completes
    assign start_permit_o = !(s_reg.sens_en && !s_reg.cal_valid)
                            && s_reg.cal_st == CAL_IDLE;
    assign cal_req_o      = s_reg.cal_st == CAL_RUN;
    assign pready_o       = 1'b1;
    assign pslverr_o      = psel_i && penable_i && !mapped;
    assign prdata_o       = s_reg.prdata;
    assign irq_o          = |(s_reg.irq_st & s_reg.irq_mask);

    always_comb begin
        prot_o.therm_fault = s_reg.therm_q && s_reg.fault_en[`GFM_EN_THERM];
        prot_o.therm_alarm = s_reg.therm_q && s_reg.alarm_en[`GFM_EN_THERM];
        prot_o.leak_fault  = s_reg.leak_trip && s_reg.fault_en[`GFM_EN_LEAK];
        prot_o.leak_alarm  = s_reg.leak_alarm && s_reg.alarm_en[`GFM_EN_LEAK];
    end

endmodule

// ==== tb/gfm_core_assertions.sv ====
/*
 * Checker of gfm_core: APB answer and refusal, read clamps, calibration handshake.
 * Assumes a bind onto gfm_core and the single ref_clk_i domain.
 */
`timescale 1ns/1ps
module gfm_core_assertions (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // APB
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic        pready_o,
    input  wire logic        pslverr_o,
    input  wire logic [31:0] prdata_o,
    // Calibration
    input  wire logic        cal_req_o,
    input  wire logic        cal_done_i,
    input  wire logic        start_permit_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       acc;
    logic [5:0] idx;
    assign acc = psel_i && penable_i;
    assign idx = paddr_i[7:2];
    ////////////////////////////////////////////////////////////////////////
    zero_wait_a: assert property (acc |-> pready_o) else $error("access not answered");
    unmapped_err_a: assert property (acc && (idx == 6'h00 || idx > 6'h16)
        |-> pslverr_o && (pwrite_i || prdata_o == 32'h0)) else $error("unmapped not refused");
    mapped_ok_a: assert property (acc && idx != 6'h00 && idx <= 6'h16 |-> !pslverr_o)
        else $error("mapped access refused");
    ready_bit_a: assert property (acc && !pwrite_i && idx == 6'h01
        |-> prdata_o[0] == !$past(cal_req_o)) else $error("ready bit wrong");
    amps_clamp_a: assert property (acc && !pwrite_i && idx inside {6'h06, 6'h08, 6'h0b}
        |-> prdata_o <= 32'h1f4) else $error("current above range");
    upper_zero_a: assert property (acc && !pwrite_i && idx >= 6'h05 && idx <= 6'h12
        |-> prdata_o[31:16] == 16'h0) else $error("upper bits set");
    cal_hold_a: assert property (cal_req_o && !cal_done_i |=> cal_req_o)
        else $error("calibration dropped early");
    cal_end_a: assert property (cal_req_o && cal_done_i |=> !cal_req_o)
        else $error("calibration not ended");
    permit_low_a: assert property (cal_req_o |-> !start_permit_o)
        else $error("start allowed in calibration");
    restore_cal_a: assert property (acc && pwrite_i && idx == 6'h13 && pwdata_i[0]
        && !cal_req_o |=> cal_req_o) else $error("restore did not calibrate");
    cover property ($rose(cal_req_o));
    cover property (acc && pslverr_o);
    cover property (acc && !pwrite_i && idx == 6'h01 && !prdata_o[0]);
endmodule

bind gfm_core gfm_core_assertions u_chk (
    .ref_clk_i      (ref_clk_i),
    .rst_n_i        (rst_n_i),
    .psel_i         (psel_i),
    .penable_i      (penable_i),
    .pwrite_i       (pwrite_i),
    .paddr_i        (paddr_i),
    .pwdata_i       (pwdata_i),
    .pready_o       (pready_o),
    .pslverr_o      (pslverr_o),
    .prdata_o       (prdata_o),
    .cal_req_o      (cal_req_o),
    .cal_done_i     (cal_done_i),
    .start_permit_o (start_permit_o)
);

// ==== tb/gfm_cal_model.sv ====
/*
 * Measuring engine model: answers a calibration request with a done pulse.
 * Assumes the request is a level held until the pulse.
 */
`timescale 1ns/1ps
module gfm_cal_model
    import gfm_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            rst_n_i,
    // Answer speed and result to deliver
    input  wire logic            slow_i,
    input  wire gfm_cal_result_t res_i,
    // Handshake
    input  wire logic            cal_req_i,
    output logic                 cal_done_o,
    output gfm_cal_result_t      cal_result_o
);
    logic [5:0]  wait_cnt;
    logic [95:0] noise;
    always_ff @(posedge ref_clk_i) begin
        // Result lines change every cycle outside the pulse
        noise <= rst_n_i ? {noise[94:0], ~noise[95]} : 96'h0;
        if (!rst_n_i || !cal_req_i || cal_done_o) begin
            wait_cnt   <= 6'h00;
            cal_done_o <= 1'b0;
        end else begin
            wait_cnt   <= wait_cnt + 6'h01;
            cal_done_o <= (wait_cnt == (slow_i ? 6'h28 : 6'h02));
        end
    end
    assign cal_result_o = cal_done_o ? res_i : noise;
endmodule

// ==== tb/gfm_core_bench.sv ====
/*
 * Self-checking bench of gfm_core with the engine model.
 * Assumes gfm_defs.svh on the include path; short tick for speed.
 */
`timescale 1ns/1ps
`include "gfm_defs.svh"
module gfm_core_bench
    import gfm_pkg::*;
;
    logic            clk, rst_n, psel, penable, pwrite, pready, pslverr, therm, loss, e;
    logic            start_permit, cal_req, cal_done, irq, slow;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd, seed;
    logic [15:0]     leak;
    gfm_motor_t      motor;
    gfm_cal_result_t cal_res, res_want;
    gfm_prot_t       prot;
    int              err_count, checks_done, cycles;
    logic [5:0]      ri [12] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13};
    logic [31:0]     rv [12] = '{1, 0, 0, 0, 1000, 250, 5, 250, 5, 100, 0, 100};
    logic [15:0]     lv [3]  = '{16'h01f4, 16'h01f5, 16'h0000};

    gfm_core #(.TICK_CYCLES(20)) dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .pslverr_o(pslverr), .prdata_o(prdata), .thermistor_input_i(therm),
        .sensor_loss_i(loss), .leak_current_i(leak), .motor_i(motor),
        .start_permit_o(start_permit), .cal_req_o(cal_req), .cal_done_i(cal_done),
        .cal_result_i(cal_res), .prot_o(prot), .irq_o(irq));
    gfm_cal_model model (
        .ref_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .res_i(res_want),
        .cal_req_i(cal_req), .cal_done_o(cal_done), .cal_result_o(cal_res));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] clamp(input logic [15:0] v);
        return (v > 16'h01f4) ? 32'h1f4 : {16'h0, v};
    endfunction
    task wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Master holds the request until pready is seen high, at most 50 cycles
    task apb(input logic w, input logic [5:0] i, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input logic [5:0] i, input logic [31:0] want);
        apb(1'b0, i, 32'h0);
        chk(rd, want);
    endtask
    task wait_req(input logic lvl);
        int n;
        n = 0;
        while (cal_req !== lvl && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk(cal_req, lvl);
    endtask
    task start_pulse();
        @(posedge clk);
        motor.start_cmd <= 1'b1;
        @(posedge clk);
        motor.start_cmd <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, therm, loss, slow} = '0;
        {paddr, pwdata, leak, motor} = '0;
        {err_count, checks_done, cycles} = '0;
        seed = 32'h59655f36;
        res_want = {seed, ~seed, seed ^ 32'h00ff00ff};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 12; k++) rchk(ri[k], rv[k]);
        foreach (lv[k]) begin
            apb(1'b0, lv[k][5:0] | 6'h17 * (k == 1) + 6'h3f * (k == 2), 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, e}, 32'h1);
        end
        for (int k = 2; k < 5; k++) begin
            seed = xs(seed);
            apb(1'b1, k[5:0], seed);
            rchk(k[5:0], {24'h0, seed[7:0]});
        end
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            apb(1'b1, 6'h06, {16'h0, k < 3 ? lv[k] : seed[15:0]});
            rchk(6'h06, clamp(k < 3 ? lv[k] : seed[15:0]));
            leak <= seed[31:16] >> (k * 4);
            repeat (3) @(posedge clk);
            rchk(6'h0b, clamp(seed[31:16] >> (k * 4)));
        end
        leak <= 16'h0;
        apb(1'b1, 6'h0d, 32'h1234);
        rchk(6'h0d, 32'h64);
        apb(1'b1, 6'h02, 32'h01);
        for (int k = 1; k < 4; k++) begin
            {loss, therm} <= k[1:0];
            repeat (3) @(posedge clk);
            rchk(6'h01, {29'h0, k[1:0], 1'b1});
            chk({31'h0, prot.therm_fault}, {31'h0, k[0]});
        end
        {loss, therm} <= 2'b00;
        apb(1'b1, 6'h14, 32'h1f);
        apb(1'b1, 6'h15, 32'h04);
        apb(1'b1, 6'h0c, 32'h1);
        slow <= 1'b1;
        start_pulse();
        wait_req(1'b1);
        chk(start_permit, 1'b0);
        rchk(6'h01, 32'h0);
        wait_req(1'b0);
        rchk(6'h0d, {16'h0, res_want.gain_a});
        rchk(6'h12, {16'h0, res_want.angle_c});
        @(negedge clk);
        chk(irq, 1'b1);
        apb(1'b1, 6'h15, 32'h0);
        @(negedge clk);
        chk(irq, 1'b0);
        apb(1'b1, 6'h15, 32'h04);
        apb(1'b1, 6'h14, 32'h04);
        rchk(6'h14, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, 6'h06, 32'd100);
        apb(1'b1, 6'h07, 32'd2);
        apb(1'b1, 6'h08, 32'd300);
        apb(1'b1, 6'h09, 32'd2);
        apb(1'b1, 6'h0a, 32'd5);
        apb(1'b1, 6'h02, 32'h02);
        apb(1'b1, 6'h03, 32'h02);
        motor.starting <= 1'b1;
        leak <= 16'd200;
        start_pulse();
        repeat (80) @(negedge clk);
        chk(cal_req, 1'b0);
        chk(prot.leak_fault, 1'b0);
        repeat (200) @(negedge clk);
        chk({prot.leak_fault, prot.leak_alarm}, 2'b10);
        leak <= 16'd350;
        repeat (200) @(negedge clk);
        chk(prot.leak_alarm, 1'b1);
        rchk(6'h14, 32'h03);
        apb(1'b1, 6'h02, 32'h0);
        @(negedge clk);
        chk(prot.leak_fault, 1'b0);
        {motor.starting, leak, slow} <= '0;
        apb(1'b1, 6'h16, 32'h1);
        wait_req(1'b1);
        wait_req(1'b0);
        motor.stopped <= 1'b1;
        motor.test_pushbutton <= 1'b1;
        repeat (1800) @(negedge clk);
        chk(cal_req, 1'b0);
        wait_req(1'b1);
        motor.test_pushbutton <= 1'b0;
        wait_req(1'b0);
        apb(1'b1, 6'h05, 32'h200);
        apb(1'b1, 6'h13, 32'h1);
        wait_req(1'b1);
        wait_req(1'b0);
        rchk(6'h05, 32'd1000);
        rchk(6'h0c, 32'h0);
        wrap_up();
    end
endmodule
